// file: tb/gpsr_pin_model.sv
// Board and peripheral model on the far side of the GPIO pins
`timescale 1ns/100ps
module gpsr_pin_model (
  input wire logic [23:0] pin_out,
  input wire logic [23:0] pin_oe_n,
  input wire logic [23:0] ext_val,
  input wire logic [4:0] per_val,
  input wire logic [3:0] per_oe,
  output logic [23:0] pin_in,
  output logic timer1_output_pin,
  output logic spi_ss_out,
  output logic spi_ss_oe,
  output logic spi_sck_out,
  output logic spi_sck_oe,
  output logic spi_mosi_out,
  output logic spi_mosi_oe,
  output logic spi_miso_out,
  output logic spi_miso_oe
);
  // Released pins take the outside level; idle outside level is the pull-up
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_val);
  // Peripheral drive towards the port C pins
  assign {spi_miso_out, spi_mosi_out, spi_sck_out, spi_ss_out, timer1_output_pin} = per_val;
  assign {spi_miso_oe, spi_mosi_oe, spi_sck_oe, spi_ss_oe} = per_oe;
endmodule : gpsr_pin_model

// file: tb/gpsr_port_props.sv
// Concurrent checks on the bus and pin ports of the GPIO port block
`timescale 1ns/100ps
module gpsr_port_props
  import gpsr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [23:0] pin_in,
  input wire logic [23:0] pin_out,
  input wire logic [23:0] pin_oe_n,
  input wire logic [23:0] pin_event,
  input wire logic irq,
  input wire logic timer1_input_pin
);
  // ==========================================================================
  // Helpers
  logic acc;
  logic [2:0] age_ff;
  assign acc = hsel & hready & htrans[1];
  // Synchroniser flops hold reset values for a few cycles after release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) age_ff <= 3'h0;
    else if (age_ff != 3'h7) age_ff <= age_ff + 3'h1;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd;
    acc && !hwrite;
  endsequence
  sequence s_out_wr;
    acc && hwrite && haddr == 8'h0C ##1 1'b1;
  endsequence

  // ==========================================================================
  // Properties
  a_read_wait: assert property (s_rd |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (acc && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_unmapped_zero: assert property (acc && !hwrite && haddr == 8'h3C |-> ##2 hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_out_drive: assert property (s_out_wr |->
    ##2 ((pin_out[7:0] ^ $past(hwdata[7:0], 2)) & ~pin_oe_n[7:0]) == 8'h00)
    else $error("driven pins differ from output value");
  a_event_edge: assert property ($changed(pin_in[23:8]) |-> ##[2:5] pin_event[23:8] != 16'h0)
    else $error("edge on port B or C gave no event");
  a_event_pulse: assert property ((pin_event & $past(pin_event)) == 24'h0)
    else $error("event longer than one cycle");
  a_event_cause: assert property ((pin_event & ~($past(pin_in, 3) ^ $past(pin_in, 4))) == 24'h0)
    else $error("event without a pin edge");
  a_timer_sync: assert property (age_ff == 3'h7 |-> timer1_input_pin == $past(pin_in[16], 3))
    else $error("timer input not three flops behind pin");
  a_mask_clear: assert property (acc && hwrite && haddr == GPSR_OFS_IRQ_MASK
    ##1 hwdata[23:0] == 24'h0 |-> ##2 !irq)
    else $error("irq high with mask cleared");
endmodule : gpsr_port_props

// file: tb/testbench.sv
// Self-checking bench for the GPIO sub-register port block
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("FAIL %s exp %0h got %0h", nm, exp, got); \
  end \
end
module testbench
  import gpsr_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = GPSR_HTRANS_IDLE;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hready, hresp, irq;
  logic [23:0] pin_in, pin_out, pin_oe_n, pin_event;
  logic [23:0] ext_val = 24'hFFFFFF;
  logic [4:0] per_val = 5'h00;
  logic [3:0] per_oe = 4'h0;
  logic t1_o, ss_o, ss_e, sck_o, sck_e, mosi_o, mosi_e, miso_o, miso_e;
  logic t1_in, ss_in, sck_in, mosi_in, miso_in;
  int err_total = 0;
  int checks_done = 0;
  always #5 hclk = ~hclk;

  gpsr_port i_gpsr_port (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_event(pin_event), .irq(irq), .timer1_output_pin(t1_o),
    .spi_ss_out(ss_o), .spi_ss_oe(ss_e), .spi_sck_out(sck_o), .spi_sck_oe(sck_e),
    .spi_mosi_out(mosi_o), .spi_mosi_oe(mosi_e), .spi_miso_out(miso_o),
    .spi_miso_oe(miso_e), .timer1_input_pin(t1_in), .spi_ss_in(ss_in),
    .spi_sck_in(sck_in), .spi_mosi_in(mosi_in), .spi_miso_in(miso_in));
  gpsr_pin_model i_gpsr_pin_model (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_val(ext_val), .per_val(per_val), .per_oe(per_oe), .pin_in(pin_in),
    .timer1_output_pin(t1_o), .spi_ss_out(ss_o), .spi_ss_oe(ss_e), .spi_sck_out(sck_o),
    .spi_sck_oe(sck_e), .spi_mosi_out(mosi_o), .spi_mosi_oe(mosi_e),
    .spi_miso_out(miso_o), .spi_miso_oe(miso_e));

  // ==========================================================================
  // Bus tasks: entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= GPSR_HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= GPSR_HTRANS_IDLE;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  function automatic logic [7:0] ra(input int p, input logic [1:0] r);
    return 8'(p) * GPSR_PORT_STRIDE + {4'h0, r, 2'b00};
  endfunction : ra
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask : chk_rd
  task automatic sub_wr(input int p, input logic [7:0] code, input logic [7:0] d);
    bus(1'b1, ra(p, GPSR_REG_SELECTOR), {24'h0, code});
    bus(1'b1, ra(p, GPSR_REG_WINDOW), {24'h0, d});
  endtask : sub_wr
  task automatic sub_rd(input string nm, input int p, input logic [7:0] code,
                        input logic [7:0] e);
    bus(1'b1, ra(p, GPSR_REG_SELECTOR), {24'h0, code});
    chk_rd(nm, ra(p, GPSR_REG_WINDOW), {24'h0, e});
  endtask : sub_rd
  task automatic wait_clk(input int n);
    repeat (n) @(posedge hclk);
  endtask : wait_clk
  // One pin edge, then status and irq, then a write-one clear
  task automatic edge_step(input int b, input logic v, input logic [23:0] e, input logic q);
    ext_val[b] <= v;
    wait_clk(6);
    chk_rd("irq status", GPSR_OFS_IRQ_STATUS, {8'h0, e});
    `CHK("irq line", q, irq)
    bus(1'b1, GPSR_OFS_IRQ_STATUS, 32'h00FFFFFF);
    wait_clk(2);
    `CHK("irq after clear", 1'b0, irq)
  endtask : edge_step
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // ==========================================================================
  // Tests
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK("oe after reset", 24'hFFFFFF, pin_oe_n)
    for (int p = 0; p < 3; p++) begin
      chk_rd("selector", ra(p, GPSR_REG_SELECTOR), 32'h0);
      sub_rd("direction", p, GPSR_SEL_DIRECTION, 8'hFF);
      sub_rd("alt select", p, GPSR_SEL_ALT_SELECT, 8'h00);
      sub_rd("open drain", p, GPSR_SEL_OPEN_DRAIN, 8'h00);
      chk_rd("output", ra(p, GPSR_REG_OUTPUT), 32'h0);
    end
    bus(1'b1, ra(1, GPSR_REG_SELECTOR), 32'h04);
    chk_rd("selector back", ra(1, GPSR_REG_SELECTOR), 32'h04);
    chk_rd("window no sub", ra(1, GPSR_REG_WINDOW), 32'h0);
    chk_rd("unmapped", 8'h3C, 32'h0);
    // Port A as plain outputs, then open-drain
    sub_wr(0, GPSR_SEL_DIRECTION, 8'h00);
    bus(1'b1, ra(0, GPSR_REG_OUTPUT), 32'hA5);
    wait_clk(2);
    `CHK("pin drive", 16'h00A5, {pin_oe_n[7:0], pin_out[7:0]})
    wait_clk(4);
    chk_rd("input", ra(0, GPSR_REG_INPUT), 32'hA5);
    sub_wr(0, GPSR_SEL_OPEN_DRAIN, 8'hFF);
    sub_rd("open drain rw", 0, GPSR_SEL_OPEN_DRAIN, 8'hFF);
    wait_clk(2);
    `CHK("open drain oe", 8'hA5, pin_oe_n[7:0])
    sub_wr(0, GPSR_SEL_DIRECTION, 8'hFF);
    // Port C handed to timer and SPI; alt bits only where a function exists
    per_val <= 5'b10101;
    per_oe <= 4'b1011;
    ext_val[16] <= 1'b0;
    sub_wr(2, GPSR_SEL_ALT_SELECT, 8'h3F);
    sub_rd("alt rw", 2, GPSR_SEL_ALT_SELECT, 8'h3F);
    `CHK("alt oe", 6'b010001, pin_oe_n[21:16])
    `CHK("alt out", 4'b1101, {pin_out[21], pin_out[19:17]})
    sub_wr(2, GPSR_SEL_OPEN_DRAIN, 8'h08);
    wait_clk(5);
    `CHK("alt open drain", 1'b1, pin_oe_n[19])
    `CHK("spi inputs", 5'b11100, {miso_in, mosi_in, sck_in, ss_in, t1_in})
    // Edge interrupts: port B both edges, port A selectable
    bus(1'b1, GPSR_OFS_IRQ_STATUS, 32'h00FFFFFF);
    chk_rd("status clear", GPSR_OFS_IRQ_STATUS, 32'h0);
    bus(1'b1, GPSR_OFS_IRQ_MASK, 32'h000100);
    edge_step(8, 1'b0, 24'h000100, 1'b1);
    edge_step(8, 1'b1, 24'h000100, 1'b1);
    edge_step(0, 1'b0, 24'h000000, 1'b0);
    edge_step(0, 1'b1, 24'h000001, 1'b0);
    bus(1'b1, GPSR_OFS_EDGE_SELECT, 32'h01);
    edge_step(0, 1'b0, 24'h000001, 1'b0);
    edge_step(0, 1'b1, 24'h000000, 1'b0);
    edge_step(9, 1'b0, 24'h000200, 1'b0);
    bus(1'b1, GPSR_OFS_IRQ_MASK, 32'h0);
    wait_clk(3);
    end_of_test();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge hclk);
    $display("FAIL watchdog exp finish got hang");
    err_total++;
    end_of_test();
  end
endmodule : testbench

bind gpsr_port gpsr_port_props i_gpsr_port_props (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pin_in, .pin_out, .pin_oe_n,
  .pin_event, .irq, .timer1_input_pin);

// file: verilog/gpsr_edge_detect.sv
// Pin synchroniser and edge detector
`timescale 1ns/100ps
module gpsr_edge_detect
  import gpsr_pkg::*;
#(
  parameter int unsigned WIDTH = GPSR_ALL_PINS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] pin_raw,
  gpsr_edge_if.det edge_bus
);

  logic [WIDTH-1:0] sync1_ff;
  logic [WIDTH-1:0] sync2_ff;
  logic [WIDTH-1:0] prev_ff;
  logic [2:0] fill_ff;
  logic armed;

  // ==========================================================================
  // Two-stage synchroniser; the first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
    end
  end

  // ==========================================================================
  // Edge detection on the settled level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_ff <= '0;
      fill_ff <= 3'h0;
    end else begin
      prev_ff <= sync2_ff;
      fill_ff <= {fill_ff[1:0], 1'b1};
    end
  end

  // Reset zeros still in the pipe would look like edges on pins idling high
  assign armed = fill_ff[2];

  // One-cycle pulses per edge
  assign edge_bus.level = sync2_ff;
  assign edge_bus.rise = sync2_ff & ~prev_ff & {WIDTH{armed}};
  assign edge_bus.fall = ~sync2_ff & prev_ff & {WIDTH{armed}};

endmodule : gpsr_edge_detect

// file: verilog/gpsr_edge_if.sv
// Synchronised pin levels and edge pulses between detector and port logic
`timescale 1ns/100ps
interface gpsr_edge_if #(
  parameter int unsigned WIDTH = 24
);
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] rise;
  logic [WIDTH-1:0] fall;

  modport det (output level, output rise, output fall);
  modport use_side (input level, input rise, input fall);
endinterface : gpsr_edge_if

// file: verilog/gpsr_pkg.sv
// Constants and types shared by the GPIO sub-register port block
package gpsr_pkg;

  // ==========================================================================
  // Geometry
  localparam int unsigned GPSR_PORT_NUM = 3;
  localparam int unsigned GPSR_PIN_NUM = 8;
  localparam int unsigned GPSR_ALL_PINS = GPSR_PORT_NUM * GPSR_PIN_NUM;

  // ==========================================================================
  // Byte offsets and port register indices: port x base is x * GPSR_PORT_STRIDE
  localparam logic [7:0] GPSR_PORT_STRIDE = 8'h10;
  localparam logic [1:0] GPSR_REG_SELECTOR = 2'h0;
  localparam logic [1:0] GPSR_REG_WINDOW = 2'h1;
  localparam logic [1:0] GPSR_REG_INPUT = 2'h2;
  localparam logic [1:0] GPSR_REG_OUTPUT = 2'h3;
  localparam logic [7:0] GPSR_OFS_IRQ_STATUS = 8'h30;
  localparam logic [7:0] GPSR_OFS_IRQ_MASK = 8'h34;
  localparam logic [7:0] GPSR_OFS_EDGE_SELECT = 8'h38;

  // ==========================================================================
  // Selector codes for the access window
  localparam logic [7:0] GPSR_SEL_DIRECTION = 8'h01;
  localparam logic [7:0] GPSR_SEL_ALT_SELECT = 8'h02;
  localparam logic [7:0] GPSR_SEL_OPEN_DRAIN = 8'h03;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] GPSR_RST_SELECTOR = 8'h00;
  localparam logic [7:0] GPSR_RST_DIRECTION = 8'hFF;
  localparam logic [7:0] GPSR_RST_ALT_SELECT = 8'h00;
  localparam logic [7:0] GPSR_RST_OPEN_DRAIN = 8'h00;
  localparam logic [7:0] GPSR_RST_OUTPUT = 8'h00;
  localparam logic [7:0] GPSR_RST_EDGE_SELECT = 8'h00;
  localparam logic [23:0] GPSR_RST_IRQ = 24'h000000;

  // ==========================================================================
  // Port C alternate-function pin positions
  localparam int unsigned GPSR_PORT_C = 2;
  localparam int unsigned GPSR_PC_TIMER1_IN = 0;
  localparam int unsigned GPSR_PC_TIMER1_OUT = 1;
  localparam int unsigned GPSR_PC_SPI_SS = 2;
  localparam int unsigned GPSR_PC_SPI_SCK = 3;
  localparam int unsigned GPSR_PC_SPI_MOSI = 4;
  localparam int unsigned GPSR_PC_SPI_MISO = 5;

  // ==========================================================================
  // AHB transfer-type codes
  typedef enum logic [1:0] {
    GPSR_HTRANS_IDLE = 2'b00,
    GPSR_HTRANS_BUSY = 2'b01,
    GPSR_HTRANS_NONSEQ = 2'b10,
    GPSR_HTRANS_SEQ = 2'b11
  } gpsr_htrans_e;

endpackage : gpsr_pkg

// file: verilog/gpsr_port.sv
// GPIO ports A to C with sub-register configuration, AHB-Lite slave
//
// Operation
// - Every port has a selector, an access window, an input value and an output value register.
// - The selector value picks which sub-register the window reads and writes.
// - Selector 02H routes the window to the eight alternate-select bits, one per pin.
// - A pin with its alternate bit clear is plain I/O steered by its direction bit.
// - A port C pin with its alternate bit set is driven by its peripheral function; on ports A and B it is released.
// - Selector 03H routes the window to the eight open-drain bits, one per pin.
// - A set open-drain bit makes the pin open-drain, alternate drive included.
// - Open-drain acts apart from the alternate bit and only removes the high drive.
// - Port A pins raise a request on a rising or a falling edge, as software selects.
// - Port B and C pins raise a request on every edge.
// - Port C pins 0 to 5 carry timer 1 in, timer 1 out, SPI select, clock, MOSI and MISO.
//
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/100ps
module gpsr_port
  import gpsr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [23:0] pin_in,
  output logic [23:0] pin_out,
  output logic [23:0] pin_oe_n,
  output logic [23:0] pin_event,
  output logic irq,
  input wire logic timer1_output_pin,
  input wire logic spi_ss_out,
  input wire logic spi_ss_oe,
  input wire logic spi_sck_out,
  input wire logic spi_sck_oe,
  input wire logic spi_mosi_out,
  input wire logic spi_mosi_oe,
  input wire logic spi_miso_out,
  input wire logic spi_miso_oe,
  output logic timer1_input_pin,
  output logic spi_ss_in,
  output logic spi_sck_in,
  output logic spi_mosi_in,
  output logic spi_miso_in
);

  // ==========================================================================
  // Decoding helpers
  function automatic logic gpsr_is_port(input logic [7:0] addr);
    gpsr_is_port = (addr[7:6] == 2'h0) && (addr[5:4] != 2'h3);
  endfunction : gpsr_is_port

  function automatic logic [1:0] gpsr_port_of(input logic [7:0] addr);
    gpsr_port_of = addr[5:4];
  endfunction : gpsr_port_of

  // ==========================================================================
  // Storage
  logic [2:0][7:0] selector_ff;
  logic [2:0][7:0] direction_ff;
  logic [2:0][7:0] alt_select_ff;
  logic [2:0][7:0] open_drain_ff;
  logic [2:0][7:0] out_value_ff;
  logic [7:0] edge_select_ff;
  logic [23:0] irq_status_ff;
  logic [23:0] irq_mask_ff;
  logic [23:0] pin_out_ff;
  logic [23:0] pin_oe_n_ff;
  logic [23:0] pin_event_ff;
  logic irq_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic wr_pend_ff;
  logic rd_pend_ff;
  logic [7:0] addr_ff;
  logic timer1_input_pin_ff;
  logic spi_ss_in_ff;
  logic spi_sck_in_ff;
  logic spi_mosi_in_ff;
  logic spi_miso_in_ff;

  logic addr_phase;
  logic wr_port_hit;
  logic [1:0] wr_port;
  logic [23:0] pin_level;
  logic [23:0] pin_ev;
  logic [7:0] pc_alt_out;
  logic [7:0] pc_alt_oe;
  logic [23:0] nxt_pin_out;
  logic [23:0] nxt_pin_oe_n;
  logic [23:0] nxt_irq_status;
  logic [31:0] nxt_hrdata;

  // ==========================================================================
  // Synchroniser and edge detector
  gpsr_edge_if #(.WIDTH(GPSR_ALL_PINS)) edge_bus ();

  gpsr_edge_detect #(.WIDTH(GPSR_ALL_PINS)) u_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_raw(pin_in),
    .edge_bus(edge_bus.det)
  );

  assign pin_level = edge_bus.level;

  // ==========================================================================
  // AHB-Lite address phase
  // Reads take one wait state so a selector write just before them is seen
  assign addr_phase = hsel && hready && (htrans[1] == 1'b1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= addr_phase && hwrite;
      rd_pend_ff <= addr_phase && !hwrite;
      if (addr_phase) begin
        addr_ff <= haddr;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b1;
    end else begin
      hreadyout_ff <= !(addr_phase && !hwrite);
    end
  end

  assign wr_port_hit = wr_pend_ff && gpsr_is_port(addr_ff);
  assign wr_port = gpsr_port_of(addr_ff);

  // ==========================================================================
  // Per-port registers
  for (genvar p = 0; p < GPSR_PORT_NUM; p++) begin : g_port
    logic wr_me;
    assign wr_me = wr_port_hit && (wr_port == 2'(p));

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        selector_ff[p] <= GPSR_RST_SELECTOR;
      end else if (wr_me && (addr_ff[3:2] == GPSR_REG_SELECTOR)) begin
        selector_ff[p] <= hwdata[7:0];
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        out_value_ff[p] <= GPSR_RST_OUTPUT;
      end else if (wr_me && (addr_ff[3:2] == GPSR_REG_OUTPUT)) begin
        out_value_ff[p] <= hwdata[7:0];
      end
    end

    // Window writes land in the sub-register the selector names
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        direction_ff[p] <= GPSR_RST_DIRECTION;
        alt_select_ff[p] <= GPSR_RST_ALT_SELECT;
        open_drain_ff[p] <= GPSR_RST_OPEN_DRAIN;
      end else if (wr_me && (addr_ff[3:2] == GPSR_REG_WINDOW)) begin
        case (selector_ff[p])
          GPSR_SEL_DIRECTION: begin
            direction_ff[p] <= hwdata[7:0];
          end
          GPSR_SEL_ALT_SELECT: begin
            alt_select_ff[p] <= hwdata[7:0];
          end
          GPSR_SEL_OPEN_DRAIN: begin
            open_drain_ff[p] <= hwdata[7:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Interrupt control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_ff <= GPSR_RST_IRQ;
    end else if (wr_pend_ff && (addr_ff == GPSR_OFS_IRQ_MASK)) begin
      irq_mask_ff <= hwdata[23:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_select_ff <= GPSR_RST_EDGE_SELECT;
    end else if (wr_pend_ff && (addr_ff == GPSR_OFS_EDGE_SELECT)) begin
      edge_select_ff <= hwdata[7:0];
    end
  end

  // ==========================================================================
  // Edge events: port A per-pin polarity, ports B and C any edge
  always_comb begin
    pin_ev = edge_bus.rise | edge_bus.fall;
    for (int i = 0; i < GPSR_PIN_NUM; i++) begin
      pin_ev[i] = edge_select_ff[i] ? edge_bus.fall[i] : edge_bus.rise[i];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_event_ff <= GPSR_RST_IRQ;
    end else begin
      pin_event_ff <= pin_ev;
    end
  end

  // Write-one-to-clear; a new edge in the same cycle keeps its bit set
  always_comb begin
    nxt_irq_status = irq_status_ff;
    if (wr_pend_ff && (addr_ff == GPSR_OFS_IRQ_STATUS)) begin
      nxt_irq_status = nxt_irq_status & ~hwdata[23:0];
    end
    nxt_irq_status = nxt_irq_status | pin_ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_ff <= GPSR_RST_IRQ;
      irq_ff <= 1'b0;
    end else begin
      irq_status_ff <= nxt_irq_status;
      irq_ff <= |(nxt_irq_status & irq_mask_ff);
    end
  end

  // ==========================================================================
  // Port C peripheral drive; pins 6 and 7 have no peripheral and stay released
  always_comb begin
    pc_alt_out = 8'h00;
    pc_alt_oe = 8'h00;
    pc_alt_out[GPSR_PC_TIMER1_OUT] = timer1_output_pin;
    pc_alt_oe[GPSR_PC_TIMER1_OUT] = 1'b1;
    pc_alt_out[GPSR_PC_SPI_SS] = spi_ss_out;
    pc_alt_oe[GPSR_PC_SPI_SS] = spi_ss_oe;
    pc_alt_out[GPSR_PC_SPI_SCK] = spi_sck_out;
    pc_alt_oe[GPSR_PC_SPI_SCK] = spi_sck_oe;
    pc_alt_out[GPSR_PC_SPI_MOSI] = spi_mosi_out;
    pc_alt_oe[GPSR_PC_SPI_MOSI] = spi_mosi_oe;
    pc_alt_out[GPSR_PC_SPI_MISO] = spi_miso_out;
    pc_alt_oe[GPSR_PC_SPI_MISO] = spi_miso_oe;
  end

  // ==========================================================================
  // Pin drive: open-drain removes only the high drive, on any source
  always_comb begin
    logic drive;
    logic value;
    drive = 1'b0;
    value = 1'b0;
    nxt_pin_out = '0;
    nxt_pin_oe_n = '1;
    for (int p = 0; p < GPSR_PORT_NUM; p++) begin
      for (int b = 0; b < GPSR_PIN_NUM; b++) begin
        if (!alt_select_ff[p][b]) begin
          drive = !direction_ff[p][b];
          value = out_value_ff[p][b];
        end else if (p == GPSR_PORT_C) begin
          drive = pc_alt_oe[b];
          value = pc_alt_out[b];
        end else begin
          drive = 1'b0;
          value = 1'b0;
        end
        if (open_drain_ff[p][b] && value) begin
          drive = 1'b0;
        end
        nxt_pin_out[p * GPSR_PIN_NUM + b] = value;
        nxt_pin_oe_n[p * GPSR_PIN_NUM + b] = !drive;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out_ff <= '0;
      pin_oe_n_ff <= '1;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_n_ff <= nxt_pin_oe_n;
    end
  end

  // ==========================================================================
  // Port C levels to peripherals
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer1_input_pin_ff <= 1'b0;
      spi_ss_in_ff <= 1'b1;
      spi_sck_in_ff <= 1'b0;
      spi_mosi_in_ff <= 1'b0;
      spi_miso_in_ff <= 1'b0;
    end else begin
      timer1_input_pin_ff <= pin_level[16 + GPSR_PC_TIMER1_IN];
      spi_ss_in_ff <= pin_level[16 + GPSR_PC_SPI_SS];
      spi_sck_in_ff <= pin_level[16 + GPSR_PC_SPI_SCK];
      spi_mosi_in_ff <= pin_level[16 + GPSR_PC_SPI_MOSI];
      spi_miso_in_ff <= pin_level[16 + GPSR_PC_SPI_MISO];
    end
  end

  // ==========================================================================
  // Read data; unmapped addresses read zero with an OKAY answer
  always_comb begin
    logic [1:0] rp;
    rp = gpsr_port_of(addr_ff);
    nxt_hrdata = 32'h00000000;
    if (gpsr_is_port(addr_ff)) begin
      case (addr_ff[3:2])
        GPSR_REG_SELECTOR: begin
          nxt_hrdata[7:0] = selector_ff[rp];
        end
        GPSR_REG_WINDOW: begin
          case (selector_ff[rp])
            GPSR_SEL_DIRECTION: begin
              nxt_hrdata[7:0] = direction_ff[rp];
            end
            GPSR_SEL_ALT_SELECT: begin
              nxt_hrdata[7:0] = alt_select_ff[rp];
            end
            GPSR_SEL_OPEN_DRAIN: begin
              nxt_hrdata[7:0] = open_drain_ff[rp];
            end
            default: begin
              nxt_hrdata = 32'h00000000;
            end
          endcase
        end
        GPSR_REG_INPUT: begin
          nxt_hrdata[7:0] = pin_level[rp * 8 +: 8];
        end
        default: begin
          nxt_hrdata[7:0] = out_value_ff[rp];
        end
      endcase
    end else begin
      case (addr_ff)
        GPSR_OFS_IRQ_STATUS: begin
          nxt_hrdata[23:0] = irq_status_ff;
        end
        GPSR_OFS_IRQ_MASK: begin
          nxt_hrdata[23:0] = irq_mask_ff;
        end
        GPSR_OFS_EDGE_SELECT: begin
          nxt_hrdata[7:0] = edge_select_ff;
        end
        default: begin
          nxt_hrdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h00000000;
    end else if (rd_pend_ff) begin
      hrdata_ff <= nxt_hrdata;
    end
  end

  // ==========================================================================
  // Outputs
  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0;
  assign pin_out = pin_out_ff;
  assign pin_oe_n = pin_oe_n_ff;
  assign pin_event = pin_event_ff;
  assign irq = irq_ff;
  assign timer1_input_pin = timer1_input_pin_ff;
  assign spi_ss_in = spi_ss_in_ff;
  assign spi_sck_in = spi_sck_in_ff;
  assign spi_mosi_in = spi_mosi_in_ff;
  assign spi_miso_in = spi_miso_in_ff;

endmodule : gpsr_port
